// *** rri_pkg.sv ***
package rri_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_DMA_CONTROL = 8'h53;
    localparam logic [7:0] ADDR_WAP_LOW = 8'h5C;
    localparam logic [7:0] ADDR_WAP_HIGH = 8'h5D;
    localparam logic [7:0] ADDR_STOP_LOW = 8'h5E;
    localparam logic [7:0] ADDR_STOP_HIGH = 8'h5F;
    localparam logic [7:0] ADDR_HOST_MODE = 8'h20;
    localparam logic [7:0] ADDR_SPECIAL = 8'h21;
    localparam logic [7:0] ADDR_PROTECTED = 8'h22;
    localparam logic [7:0] ADDR_HARD_ONLY = 8'h23;
    localparam logic [7:0] ADDR_RESET_CAUSE = 8'h24;
    localparam logic [7:0] ADDR_FIXED_DISK = 8'h25;
    // Field positions
    localparam int MODE_SECOND_BIT = 0;
    localparam int FDC_RESET_BIT = 2;
    localparam int DMA_AUTO_BIT = 2;
    localparam int SPECIAL_FORCE_BIT = 4;
    localparam int CAUSE_HOST_BUS_BIT = 0;
    localparam int CAUSE_PROGRAM_BIT = 1;
    localparam int CAUSE_CMD_INIT_BIT = 2;
    // Values after reset and after command initialization
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] DMA_AUTO_VALUE = 8'(1 << DMA_AUTO_BIT);
    localparam logic [15:0] WAP_AUTO_VALUE = 16'h0000;
    localparam logic [15:0] STOP_AUTO_VALUE = 16'h01FF;
    // Host command opcodes
    localparam logic [7:0] CMD_DIAGNOSTIC = 8'h90;
    localparam logic [7:0] CMD_AUTO_CONFIG = 8'hA0;
endpackage

// *** rri_sync3.sv ***
`timescale 1ns/10ps
`default_nettype none
module rri_sync3
    import rri_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Pin side and clean side
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;
    logic stage2;
    logic stage3;

    // Three-stage shift, first stage read only by the second
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3 <= 1'b0;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // Change accepted once second and third stages agree
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync_out <= 1'b0;
        end else if (stage2 == stage3) begin
            sync_out <= stage3;
        end
    end
endmodule
`default_nettype wire

// *** rri_reset_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module rri_reset_decode
    import rri_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Sources
    input wire logic second_mode,
    input wire logic port1_write,
    input wire logic fdc_reset_bit,
    input wire logic cmd_write,
    input wire logic [7:0] cmd_byte,
    // Decoded strobes
    output logic prog_reset,
    output logic cmd_clear,
    output logic cmd_init
);
    logic fdc_reset_prev;

    // Previous value of the fixed disk reset bit for edge finding
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fdc_reset_prev <= 1'b0;
        end else begin
            fdc_reset_prev <= fdc_reset_bit;
        end
    end

    assign prog_reset = (!second_mode && port1_write) ||
                        (second_mode && fdc_reset_bit && !fdc_reset_prev);
    assign cmd_clear = cmd_write;
    assign cmd_init = cmd_write && second_mode &&
                      ((cmd_byte == CMD_AUTO_CONFIG) ||
                       (cmd_byte == CMD_DIAGNOSTIC));
endmodule
`default_nettype wire

// *** rri_reset_init.sv ***
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module rri_reset_init
    import rri_pkg::*;
(
    // Clock and local reset pin
    input wire logic clock,
    input wire logic reset_n,
    // Host bus reset pin, active high
    input wire logic host_bus_reset_pin,
    // Host interface events
    input wire logic host_port1_write,
    input wire logic host_fdc_write,
    input wire logic host_cmd_write,
    input wire logic [7:0] host_data,
    input wire logic host_irq_raise,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Decoded reset strobes
    output logic host_bus_reset,
    output logic prog_reset_strobe,
    output logic cmd_init_strobe,
    // Register contents
    output logic [7:0] dma_control,
    output logic [15:0] buffer_write_pointer,
    output logic [15:0] host_stop_pointer,
    output logic second_mode,
    output logic host_irq
);
    logic [7:0] fixed_disk_control;
    logic [7:0] special_reg;
    logic [7:0] protected_reg;
    logic [7:0] hard_only_reg;
    logic [2:0] reset_cause;
    logic cmd_clear;
    logic host_reset_any;
    logic [7:0] next_rdata;

    // Host bus reset pin synchronizer
    rri_sync3 u_host_reset_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in(host_bus_reset_pin),
        .sync_out(host_bus_reset)
    );

    rri_reset_decode u_decode (
        .clock(clock),
        .reset_n(reset_n),
        .second_mode(second_mode),
        .port1_write(host_port1_write),
        .fdc_reset_bit(fixed_disk_control[FDC_RESET_BIT]),
        .cmd_write(host_cmd_write),
        .cmd_byte(host_data),
        .prog_reset(prog_reset_strobe),
        .cmd_clear(cmd_clear),
        .cmd_init(cmd_init_strobe)
    );

    assign host_reset_any = host_bus_reset || prog_reset_strobe;

    // Host mode select, software owned
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            second_mode <= 1'b0;
        end else if (reg_write && reg_addr == ADDR_HOST_MODE) begin
            second_mode <= reg_wdata[MODE_SECOND_BIT];
        end
    end

    // Fixed disk control, written by the second-mode host
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fixed_disk_control <= BYTE_RESET;
        end else if (host_bus_reset) begin
            fixed_disk_control <= BYTE_RESET;
        end else if (host_fdc_write && second_mode) begin
            fixed_disk_control <= host_data;
        end
    end

    // DMA control: resets, command clear and auto value
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dma_control <= BYTE_RESET;
        end else if (host_reset_any) begin
            dma_control <= BYTE_RESET;
        end else if (cmd_init_strobe) begin
            dma_control <= DMA_AUTO_VALUE;
        end else if (cmd_clear) begin
            dma_control <= BYTE_RESET;
        end else if (reg_write && reg_addr == ADDR_DMA_CONTROL) begin
            dma_control <= reg_wdata;
        end
    end

    // Buffer write pointer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            buffer_write_pointer <= WORD_RESET;
        end else if (host_reset_any) begin
            buffer_write_pointer <= WORD_RESET;
        end else if (cmd_init_strobe) begin
            buffer_write_pointer <= WAP_AUTO_VALUE;
        end else if (reg_write && reg_addr == ADDR_WAP_LOW) begin
            buffer_write_pointer[7:0] <= reg_wdata;
        end else if (reg_write && reg_addr == ADDR_WAP_HIGH) begin
            buffer_write_pointer[15:8] <= reg_wdata;
        end
    end

    // Host stop pointer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_stop_pointer <= WORD_RESET;
        end else if (host_reset_any) begin
            host_stop_pointer <= WORD_RESET;
        end else if (cmd_init_strobe) begin
            host_stop_pointer <= STOP_AUTO_VALUE;
        end else if (reg_write && reg_addr == ADDR_STOP_LOW) begin
            host_stop_pointer[7:0] <= reg_wdata;
        end else if (reg_write && reg_addr == ADDR_STOP_HIGH) begin
            host_stop_pointer[15:8] <= reg_wdata;
        end
    end

    // Special register with forced bit 4
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            special_reg <= BYTE_RESET;
        end else if (host_reset_any) begin
            special_reg <= BYTE_RESET;
            special_reg[SPECIAL_FORCE_BIT] <= 1'b1;
        end else if (reg_write && reg_addr == ADDR_SPECIAL) begin
            special_reg <= reg_wdata;
        end
    end

    // Protected register, local reset only
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            protected_reg <= BYTE_RESET;
        end else if (reg_write && reg_addr == ADDR_PROTECTED) begin
            protected_reg <= reg_wdata;
        end
    end

    // Hard-only register, cleared by the two reset pins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            hard_only_reg <= BYTE_RESET;
        end else if (host_bus_reset) begin
            hard_only_reg <= BYTE_RESET;
        end else if (reg_write && reg_addr == ADDR_HARD_ONLY) begin
            hard_only_reg <= reg_wdata;
        end
    end

    // Sticky reset cause, write one to clear, set wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reset_cause <= 3'h0;
        end else begin
            if (reg_write && reg_addr == ADDR_RESET_CAUSE) begin
                reset_cause <= reset_cause & ~reg_wdata[2:0] |
                               {cmd_init_strobe, prog_reset_strobe,
                                host_bus_reset};
            end else begin
                reset_cause <= reset_cause |
                               {cmd_init_strobe, prog_reset_strobe,
                                host_bus_reset};
            end
        end
    end

    // Host interrupt indication, raise wins over clear
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            host_irq <= 1'b0;
        end else if (host_irq_raise) begin
            host_irq <= 1'b1;
        end else if (host_port1_write || host_bus_reset) begin
            host_irq <= 1'b0;
        end
    end

    // Read multiplexer, unmapped reads zero
    always_comb begin
        next_rdata = BYTE_RESET;
        unique case (reg_addr)
            ADDR_DMA_CONTROL: next_rdata = dma_control;
            ADDR_WAP_LOW: next_rdata = buffer_write_pointer[7:0];
            ADDR_WAP_HIGH: next_rdata = buffer_write_pointer[15:8];
            ADDR_STOP_LOW: next_rdata = host_stop_pointer[7:0];
            ADDR_STOP_HIGH: next_rdata = host_stop_pointer[15:8];
            ADDR_HOST_MODE: next_rdata = {7'h00, second_mode};
            ADDR_SPECIAL: next_rdata = special_reg;
            ADDR_PROTECTED: next_rdata = protected_reg;
            ADDR_HARD_ONLY: next_rdata = hard_only_reg;
            ADDR_RESET_CAUSE: next_rdata = {5'h00, reset_cause};
            ADDR_FIXED_DISK: next_rdata = fixed_disk_control;
            default: next_rdata = BYTE_RESET;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= BYTE_RESET;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= BYTE_RESET;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence s_auto_cmd;
        host_cmd_write && second_mode && host_data == CMD_AUTO_CONFIG;
    endsequence

    sequence s_host_quiet;
        !host_bus_reset && !prog_reset_strobe;
    endsequence

    chk_port1_prog: assert property (
        (!second_mode && host_port1_write) |-> prog_reset_strobe
    ) else $error("port 1 write gave no programmed reset");

    chk_fdc_prog: assert property (
        (second_mode && host_fdc_write && host_data[FDC_RESET_BIT] &&
         !fixed_disk_control[FDC_RESET_BIT] && !host_bus_reset)
        |=> prog_reset_strobe
    ) else $error("fixed disk reset bit gave no programmed reset");

    chk_cmd_dma_clear: assert property (
        (s_host_quiet and host_cmd_write && !cmd_init_strobe)
        |=> dma_control == BYTE_RESET
    ) else $error("command write did not clear dma control");

    chk_auto_dma_value: assert property (
        (s_host_quiet and s_auto_cmd) |=> dma_control == DMA_AUTO_VALUE
    ) else $error("auto command left wrong dma control");

    chk_auto_wap_clear: assert property (
        (s_auto_cmd and s_host_quiet)
        |=> buffer_write_pointer == WAP_AUTO_VALUE
    ) else $error("auto command did not clear write pointer");

    chk_auto_stop_load: assert property (
        (s_host_quiet and s_auto_cmd) |=> host_stop_pointer == STOP_AUTO_VALUE
    ) else $error("auto command did not load stop pointer");

    chk_diag_init: assert property (
        (s_host_quiet and
         host_cmd_write && second_mode && host_data == CMD_DIAGNOSTIC)
        |-> cmd_init_strobe ##1 (dma_control == DMA_AUTO_VALUE &&
            host_stop_pointer == STOP_AUTO_VALUE)
    ) else $error("diagnostic command did not initialize");

    chk_protected_hold: assert property (
        (host_reset_any && !(reg_write && reg_addr == ADDR_PROTECTED))
        |=> $stable(protected_reg)
    ) else $error("protected register changed on host reset");

    chk_special_force: assert property (
        host_reset_any |=> special_reg[SPECIAL_FORCE_BIT]
    ) else $error("special bit not forced high");

    chk_hard_keep: assert property (
        (prog_reset_strobe && !host_bus_reset &&
         !(reg_write && reg_addr == ADDR_HARD_ONLY))
        |=> $stable(hard_only_reg)
    ) else $error("hard-only register changed on programmed reset");

    chk_irq_clear: assert property (
        ((host_port1_write || host_bus_reset) && !host_irq_raise)
        |=> !host_irq
    ) else $error("host interrupt not cleared");

    chk_read_slot: assert property (
        !reg_read |=> reg_rdata == BYTE_RESET
    ) else $error("read data outside its slot");
endmodule
`default_nettype wire

// *** rri_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module rri_host_model (
    // Clock
    input wire logic clock,
    // Host bus side
    output logic host_bus_reset_pin,
    output logic host_port1_write,
    output logic host_fdc_write,
    output logic host_cmd_write,
    output logic [7:0] host_data,
    output logic host_irq_raise
);
    // Idle host bus
    initial begin
        host_bus_reset_pin = 1'b0;
        host_port1_write = 1'b0;
        host_fdc_write = 1'b0;
        host_cmd_write = 1'b0;
        host_data = 8'h00;
        host_irq_raise = 1'b0;
    end
    // Raise one host strobe: 0 port1, 1 fdc, 2 command, 3 irq
    task automatic raise(input int kind, input logic [7:0] d);
        @(posedge clock);
        host_data <= d;
        case (kind)
            0: host_port1_write <= 1'b1;
            1: host_fdc_write <= 1'b1;
            2: host_cmd_write <= 1'b1;
            default: host_irq_raise <= 1'b1;
        endcase
    endtask
    // Strobe taken at this edge, then bus released
    task automatic drop();
        @(posedge clock);
        host_port1_write <= 1'b0;
        host_fdc_write <= 1'b0;
        host_cmd_write <= 1'b0;
        host_irq_raise <= 1'b0;
        host_data <= ~host_data; // Stale data never repeats
    endtask
    // Host bus reset pin level
    task automatic pin(input logic v);
        @(posedge clock);
        host_bus_reset_pin <= v;
    endtask
endmodule
`default_nettype wire

// *** rri_reset_init_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module rri_reset_init_tb;
    import rri_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic hb_pin, p1_wr, fdc_wr, cmd_wr, irq_raise;
    logic [7:0] hdata;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata, dma_control;
    logic host_bus_reset, prog_reset_strobe, cmd_init_strobe;
    logic [15:0] buffer_write_pointer, host_stop_pointer;
    logic second_mode, host_irq;
    int err_total = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [7:0] ops [2] = '{CMD_AUTO_CONFIG, CMD_DIAGNOSTIC};

    // 100 MHz clock
    always #5 clock = ~clock;

    rri_host_model host (.clock(clock), .host_bus_reset_pin(hb_pin),
        .host_port1_write(p1_wr), .host_fdc_write(fdc_wr),
        .host_cmd_write(cmd_wr), .host_data(hdata),
        .host_irq_raise(irq_raise));

    rri_reset_init dut (.clock(clock), .reset_n(reset_n),
        .host_bus_reset_pin(hb_pin), .host_port1_write(p1_wr),
        .host_fdc_write(fdc_wr), .host_cmd_write(cmd_wr),
        .host_data(hdata), .host_irq_raise(irq_raise),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .host_bus_reset(host_bus_reset),
        .prog_reset_strobe(prog_reset_strobe),
        .cmd_init_strobe(cmd_init_strobe), .dma_control(dma_control),
        .buffer_write_pointer(buffer_write_pointer),
        .host_stop_pointer(host_stop_pointer),
        .second_mode(second_mode), .host_irq(host_irq));

    // Verdict and end of run
    task automatic end_of_test();
        if (err_total == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Compare seen against expected
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    // Read, data in the following cycle only
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Known contents before each event
    task automatic load();
        wr(ADDR_DMA_CONTROL, 8'h11);
        wr(ADDR_WAP_LOW, 8'h22);
        wr(ADDR_WAP_HIGH, 8'h33);
        wr(ADDR_STOP_LOW, 8'h44);
        wr(ADDR_STOP_HIGH, 8'h55);
        wr(ADDR_PROTECTED, 8'hA5);
        wr(ADDR_HARD_ONLY, 8'h5A);
        wr(ADDR_SPECIAL, 8'h00);
        #1;
        chk(buffer_write_pointer, 16'h3322);
        chk(host_stop_pointer, 16'h5544);
    endtask
    // Survivors and victims of a host reset
    task automatic after_host_reset(input logic [7:0] hard);
        // Let a pending reset strobe reach the registers
        @(posedge clock);
        #1;
        chk(dma_control, 16'h0000);
        chk(buffer_write_pointer, 16'h0000);
        rchk(ADDR_PROTECTED, 8'hA5);
        rchk(ADDR_HARD_ONLY, hard);
        rchk(ADDR_SPECIAL, 8'h10);
    endtask

    // Cycle ceiling against hangs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            err_total++;
            end_of_test();
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        rchk(ADDR_DMA_CONTROL, 8'h00);
        rchk(ADDR_SPECIAL, 8'h00);
        rchk(8'h30, 8'h00);
        load();
        rchk(ADDR_DMA_CONTROL, 8'h11);
        // First mode: command only clears dma
        host.raise(2, CMD_AUTO_CONFIG);
        #1 chk(cmd_init_strobe, 1'b0);
        host.drop();
        #1 chk(dma_control, 8'h00);
        chk(host_stop_pointer, 16'h5544);
        // Second mode: init commands
        wr(ADDR_HOST_MODE, 8'h01);
        #1 chk(second_mode, 1'b1);
        for (int i = 0; i < 2; i++) begin
            load();
            host.raise(2, ops[i]);
            #1 chk(cmd_init_strobe, 1'b1);
            host.drop();
            #1 chk(dma_control, DMA_AUTO_VALUE);
            chk(buffer_write_pointer, 16'h0000);
            chk(host_stop_pointer, 16'h01FF);
        end
        load();
        host.raise(2, 8'h10);
        host.drop();
        #1 chk(dma_control, 8'h00);
        chk(host_stop_pointer, 16'h5544);
        // Second mode programmed reset through fdc bit 2
        load();
        host.raise(1, 8'h04);
        #1 chk(prog_reset_strobe, 1'b0);
        host.drop();
        #1 chk(prog_reset_strobe, 1'b1);
        after_host_reset(8'h5A);
        rchk(ADDR_FIXED_DISK, 8'h04);
        wr(ADDR_HOST_MODE, 8'h00);
        // First mode port 1 write
        load();
        host.raise(3, 8'h00);
        host.drop();
        #1 chk(host_irq, 1'b1);
        host.raise(0, 8'h00);
        #1 chk(prog_reset_strobe, 1'b1);
        host.drop();
        #1 chk(host_irq, 1'b0);
        after_host_reset(8'h5A);
        // Host bus reset pin
        load();
        host.raise(3, 8'h00);
        host.drop();
        host.pin(1'b1);
        repeat (5) @(posedge clock);
        #1 chk(host_bus_reset, 1'b1);
        chk(host_irq, 1'b0);
        host.pin(1'b0);
        repeat (6) @(posedge clock);
        #1 chk(host_bus_reset, 1'b0);
        after_host_reset(8'h00);
        rchk(ADDR_FIXED_DISK, 8'h00);
        // All three reset causes seen, then cleared by writing ones
        rchk(ADDR_RESET_CAUSE, 8'h07);
        wr(ADDR_RESET_CAUSE, 8'h07);
        rchk(ADDR_RESET_CAUSE, 8'h00);
        // Local reset in mid-run
        @(posedge clock);
        reset_n <= 1'b0;
        @(posedge clock);
        reset_n <= 1'b1;
        rchk(ADDR_SPECIAL, 8'h00);
        rchk(ADDR_PROTECTED, 8'h00);
        end_of_test();
    end
endmodule
`default_nettype wire
